/* core/aod_decoder.sv */
// Top of the arithmetic/logic opcode decoder: registers one decoded opcode per request taken while idle,
// then, for an opcode with an extra byte, collects the operand byte that follows it in program memory.
// Assumes the fetch path presents opcode and operand bytes from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module aod_decoder
  import aod_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic cond_met_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output aod_op_t op_o,
  output aod_src_t src_o,
  output aod_reg_t src_reg_o,
  output aod_reg_t dest_reg_o,
  output logic [1:0] pair_o,
  output logic [4:0] cycles_o,
  output logic [1:0] extra_bytes_o,
  output logic legal_o,
  output logic dec_valid_o,
  output logic operand_valid_o,
  output logic [7:0] operand_o,
  output logic busy_o
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Grouped ALU operation from bits 5:3 of an arithmetic/logic opcode.
  function automatic aod_op_t alu_group(input logic [2:0] grp);
    aod_op_t r;
    r = AOD_OP_ILLEGAL;
    unique case (grp)
      3'h0: r = AOD_OP_ADD;
      3'h1: r = AOD_OP_ADC;
      3'h2: r = AOD_OP_SUB;
      3'h3: r = AOD_OP_SUB_BORROW;
      3'h4: r = AOD_OP_AND;
      3'h5: r = AOD_OP_XOR;
      3'h6: r = AOD_OP_OR;
      3'h7: r = AOD_OP_COMPARE;
    endcase
    return r;
  endfunction

  typedef enum logic [1:0] {
    AOD_ST_IDLE, AOD_ST_OPERAND
  } aod_state_t;

  logic [2:0] src_field;
  logic [2:0] grp_field;
  aod_reg_t src_code;
  logic src_is_mem;
  aod_reg_t dest_code;
  logic dest_is_mem;
  logic [4:0] pick_cycles;

  assign src_field = opcode_i[AOD_SRC_LSB +: 3];
  assign grp_field = opcode_i[AOD_GRP_LSB +: 3];

  aod_reg_field u_src_field (
    .field_i(src_field),
    .reg_o(src_code),
    .is_mem_o(src_is_mem)
  );

  aod_reg_field u_dest_field (
    .field_i(grp_field),
    .reg_o(dest_code),
    .is_mem_o(dest_is_mem)
  );

  // ***************************************************************
  // Combinational decode
  // ***************************************************************
  aod_op_t d_op;
  aod_src_t d_src;
  logic [4:0] d_cyc;
  logic [1:0] d_extra;

  always_comb begin
    d_op = AOD_OP_ILLEGAL;
    d_src = AOD_SRC_NONE;
    d_cyc = AOD_CYC_4;
    d_extra = 2'h0;
    if (opcode_i[7:6] == 2'h2) begin
      d_op = alu_group(grp_field);
      d_src = src_is_mem ? AOD_SRC_MEM : AOD_SRC_REG;
      d_cyc = src_is_mem ? AOD_CYC_7 : AOD_CYC_4;
    end else if (opcode_i[7:6] == 2'h3 && src_field == AOD_FIELD_MEM) begin
      d_op = alu_group(grp_field);
      d_src = AOD_SRC_IMM;
      d_cyc = AOD_CYC_7;
      d_extra = 2'h1;
    end else if (opcode_i[7:6] == 2'h0 && opcode_i[3:0] == 4'h9 && opcode_i[5:4] != 2'h3) begin
      d_op = AOD_OP_PAIR_SUM;
      d_cyc = AOD_CYC_10;
    end else if (opcode_i[7:6] == 2'h0 && opcode_i[2:0] == 3'h3 && opcode_i[5:4] != 2'h3) begin
      d_op = opcode_i[3] ? AOD_OP_PAIR_DEC : AOD_OP_PAIR_INC;
      d_cyc = AOD_CYC_5;
    end else begin
      unique case (opcode_i)
        AOD_ROT_LEFT: d_op = AOD_OP_ROT_LEFT_CIRC;
        AOD_ROT_RIGHT: d_op = AOD_OP_ROT_RIGHT_CIRC;
        AOD_ROT_LEFT_C: d_op = AOD_OP_ROT_LEFT_CARRY;
        AOD_ROT_RIGHT_C: d_op = AOD_OP_ROT_RIGHT_CARRY;
        AOD_INV_ACC: d_op = AOD_OP_INV_ACC;
        AOD_CARRY_SET: d_op = AOD_OP_CARRY_SET;
        AOD_CARRY_INV: d_op = AOD_OP_CARRY_INV;
        AOD_DEC_ADJ: d_op = AOD_OP_DEC_ADJ;
        AOD_PORT_IN: begin
          d_op = AOD_OP_PORT_IN;
          d_cyc = AOD_CYC_10;
          d_extra = 2'h1;
        end
        AOD_PORT_OUT: begin
          d_op = AOD_OP_PORT_OUT;
          d_cyc = AOD_CYC_10;
          d_extra = 2'h1;
        end
        AOD_INT_EN: d_op = AOD_OP_INT_EN;
        AOD_INT_MASK: d_op = AOD_OP_INT_MASK;
        AOD_IDLE: d_op = AOD_OP_IDLE;
        AOD_STOP: begin
          d_op = AOD_OP_STOP;
          d_cyc = AOD_CYC_7;
        end
        default: d_op = AOD_OP_ILLEGAL;
      endcase
    end
  end

  // None of the decoded rows carry two counts; the picker is kept in the
  // path so that a flag-dependent row added later takes its count from the flag.
  aod_cycle_pick u_pick (
    .dual_i(1'b0),
    .cond_met_i(cond_met_i),
    .short_i(d_cyc),
    .long_i(d_cyc),
    .cycles_o(pick_cycles)
  );

  // ***************************************************************
  // Decode and operand registers
  // ***************************************************************
  aod_state_t st_r, st_nxt;
  aod_op_t op_r, op_nxt;
  aod_src_t src_r, src_nxt;
  aod_reg_t sreg_r, sreg_nxt, dreg_r, dreg_nxt;
  logic [1:0] pair_r, pair_nxt, extra_r, extra_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  logic legal_r, legal_nxt, dv_r, dv_nxt, ov_r, ov_nxt;
  logic [7:0] opnd_r, opnd_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    src_nxt = src_r;
    sreg_nxt = sreg_r;
    dreg_nxt = dreg_r;
    pair_nxt = pair_r;
    extra_nxt = extra_r;
    cyc_nxt = cyc_r;
    legal_nxt = legal_r;
    opnd_nxt = opnd_r;
    dv_nxt = 1'b0;
    ov_nxt = 1'b0;
    unique case (st_r)
      AOD_ST_IDLE: begin
        if (op_valid_i) begin
          op_nxt = d_op;
          src_nxt = d_src;
          sreg_nxt = src_code;
          dreg_nxt = dest_code;
          pair_nxt = opcode_i[AOD_RP_LSB +: 2];
          extra_nxt = d_extra;
          cyc_nxt = pick_cycles;
          legal_nxt = (d_op != AOD_OP_ILLEGAL);
          dv_nxt = 1'b1;
          if (d_extra != 2'h0) begin
            st_nxt = AOD_ST_OPERAND;
          end
        end
      end
      AOD_ST_OPERAND: begin
        if (byte_valid_i) begin
          opnd_nxt = byte_i;
          ov_nxt = 1'b1;
          st_nxt = AOD_ST_IDLE;
        end
      end
      default: st_nxt = AOD_ST_IDLE;
    endcase
    // Busy is registered from the next state, so the port needs no decode of the state.
    busy_nxt = (st_nxt == AOD_ST_OPERAND);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= AOD_ST_IDLE;
      op_r <= AOD_OP_ILLEGAL;
      src_r <= AOD_SRC_NONE;
      sreg_r <= AOD_REG_B;
      dreg_r <= AOD_REG_B;
      pair_r <= 2'h0;
      extra_r <= 2'h0;
      cyc_r <= AOD_CYC_RST;
      legal_r <= 1'b0;
      dv_r <= 1'b0;
      ov_r <= 1'b0;
      opnd_r <= AOD_BYTE_RST;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      src_r <= src_nxt;
      sreg_r <= sreg_nxt;
      dreg_r <= dreg_nxt;
      pair_r <= pair_nxt;
      extra_r <= extra_nxt;
      cyc_r <= cyc_nxt;
      legal_r <= legal_nxt;
      dv_r <= dv_nxt;
      ov_r <= ov_nxt;
      opnd_r <= opnd_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign op_o = op_r;
  assign src_o = src_r;
  assign src_reg_o = sreg_r;
  assign dest_reg_o = dreg_r;
  assign pair_o = pair_r;
  assign cycles_o = cyc_r;
  assign extra_bytes_o = extra_r;
  assign legal_o = legal_r;
  assign dec_valid_o = dv_r;
  assign operand_valid_o = ov_r;
  assign operand_o = opnd_r;
  assign busy_o = busy_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_take_imm;
    !busy_o && op_valid_i && opcode_i[7:6] == 2'h3 && opcode_i[2:0] == 3'h6;
  endsequence

  a_reg_alu_cycles: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i[7:6] == 2'h2 && opcode_i[2:0] != 3'h6
    |=> cycles_o == 5'h04 && src_o == AOD_SRC_REG)
    else $error("register ALU opcode not four cycles");
  a_mem_alu_cycles: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i[7:6] == 2'h2 && opcode_i[2:0] == 3'h6
    |=> cycles_o == 5'h07 && src_o == AOD_SRC_MEM)
    else $error("memory ALU opcode not seven cycles");
  a_sub_borrow_op: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i[7:3] == 5'h13 |=> op_o == AOD_OP_SUB_BORROW)
    else $error("borrow subtract misdecoded");
  a_imm_seq: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_take_imm |=> busy_o && cycles_o == 5'h07 && src_o == AOD_SRC_IMM)
    else $error("immediate opcode did not wait for operand");
  a_operand_take: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    busy_o && byte_valid_i |=> operand_valid_o && operand_o == $past(byte_i) && !busy_o)
    else $error("operand byte not captured");
  a_compare_imm: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'hfe |=> op_o == AOD_OP_COMPARE && extra_bytes_o == 2'h1)
    else $error("immediate compare misdecoded");
  a_pair_sum: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'h19 |=> op_o == AOD_OP_PAIR_SUM && cycles_o == 5'h0a)
    else $error("pair sum misdecoded");
  a_pair_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'h2b |=> op_o == AOD_OP_PAIR_DEC && cycles_o == 5'h05)
    else $error("pair decrement misdecoded");
  a_stop_cycles: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'h76 |=> op_o == AOD_OP_STOP && cycles_o == 5'h07)
    else $error("stop opcode misdecoded");
  a_port_in: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'hdb
    |=> op_o == AOD_OP_PORT_IN && busy_o && cycles_o == 5'h0a && extra_bytes_o == 2'h1)
    else $error("port input misdecoded");
  a_rot_rc: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'h1f
    |=> op_o == AOD_OP_ROT_RIGHT_CARRY && cycles_o == 5'h04)
    else $error("rotate via carry misdecoded");
  a_refuse_busy: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    busy_o && op_valid_i |=> !dec_valid_o)
    else $error("opcode taken while waiting for operand");
  a_pair_inc: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'h03 |=> op_o == AOD_OP_PAIR_INC && pair_o == 2'h0)
    else $error("pair increment misdecoded");
  a_imm_carry: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'hce |=> op_o == AOD_OP_ADC && cycles_o == 5'h07)
    else $error("immediate add with carry misdecoded");
  a_dec_adjust: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'h27 |=> op_o == AOD_OP_DEC_ADJ && cycles_o == 5'h04)
    else $error("decimal adjust misdecoded");
  a_port_out: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !busy_o && op_valid_i && opcode_i == 8'hd3 |=> op_o == AOD_OP_PORT_OUT && busy_o)
    else $error("port output misdecoded");

endmodule
`default_nettype wire

/* core/aod_pkg.sv */
// Constants, opcode encodings and cycle counts for the arithmetic/logic opcode decoder.
// Assumes a single processor clock domain; shared by the decoder and its helper modules.
package aod_pkg;

  // ***************************************************************
  // Operation classes
  // ***************************************************************
  typedef enum logic [5:0] {
    AOD_OP_ILLEGAL, AOD_OP_ADD, AOD_OP_ADC, AOD_OP_SUB, AOD_OP_SUB_BORROW,
    AOD_OP_AND, AOD_OP_XOR, AOD_OP_OR, AOD_OP_COMPARE,
    AOD_OP_ROT_LEFT_CIRC, AOD_OP_ROT_RIGHT_CIRC, AOD_OP_ROT_LEFT_CARRY, AOD_OP_ROT_RIGHT_CARRY,
    AOD_OP_PAIR_SUM, AOD_OP_PAIR_INC, AOD_OP_PAIR_DEC,
    AOD_OP_INV_ACC, AOD_OP_CARRY_SET, AOD_OP_CARRY_INV, AOD_OP_DEC_ADJ,
    AOD_OP_PORT_IN, AOD_OP_PORT_OUT, AOD_OP_INT_EN, AOD_OP_INT_MASK,
    AOD_OP_IDLE, AOD_OP_STOP
  } aod_op_t;

  typedef enum logic [1:0] {
    AOD_SRC_NONE, AOD_SRC_REG, AOD_SRC_MEM, AOD_SRC_IMM
  } aod_src_t;

  typedef enum logic [2:0] {
    AOD_REG_B, AOD_REG_C, AOD_REG_D, AOD_REG_E,
    AOD_REG_H, AOD_REG_L, AOD_REG_MEM, AOD_REG_A
  } aod_reg_t;

  // ***************************************************************
  // Field positions and fixed encodings
  // ***************************************************************
  localparam int AOD_SRC_LSB = 0;
  localparam int AOD_GRP_LSB = 3;
  localparam int AOD_RP_LSB = 4;
  localparam logic [2:0] AOD_FIELD_MEM = 3'h6;
  localparam logic [7:0] AOD_ROT_LEFT = 8'h07;
  localparam logic [7:0] AOD_ROT_RIGHT = 8'h0f;
  localparam logic [7:0] AOD_ROT_LEFT_C = 8'h17;
  localparam logic [7:0] AOD_ROT_RIGHT_C = 8'h1f;
  localparam logic [7:0] AOD_DEC_ADJ = 8'h27;
  localparam logic [7:0] AOD_INV_ACC = 8'h2f;
  localparam logic [7:0] AOD_CARRY_SET = 8'h37;
  localparam logic [7:0] AOD_CARRY_INV = 8'h3f;
  localparam logic [7:0] AOD_PORT_IN = 8'hdb;
  localparam logic [7:0] AOD_PORT_OUT = 8'hd3;
  localparam logic [7:0] AOD_INT_EN = 8'hfb;
  localparam logic [7:0] AOD_INT_MASK = 8'hf3;
  localparam logic [7:0] AOD_IDLE = 8'h00;
  localparam logic [7:0] AOD_STOP = 8'h76;

  // ***************************************************************
  // Cycle counts and reset values
  // ***************************************************************
  localparam logic [4:0] AOD_CYC_4 = 5'h04;
  localparam logic [4:0] AOD_CYC_5 = 5'h05;
  localparam logic [4:0] AOD_CYC_7 = 5'h07;
  localparam logic [4:0] AOD_CYC_10 = 5'h0a;
  localparam logic [4:0] AOD_CYC_RST = 5'h00;
  localparam logic [7:0] AOD_BYTE_RST = 8'h00;

endpackage

/* core/aod_reg_field.sv */
// Decodes a three-bit register selector field into a register code and memory flag.
// Assumes a pure combinational use inside the decoder; no clock.
`timescale 1ns/1ps
`default_nettype none
module aod_reg_field
  import aod_pkg::*;
(
  input wire logic [2:0] field_i,
  output aod_reg_t reg_o,
  output logic is_mem_o
);

  always_comb begin
    reg_o = aod_reg_t'(field_i);
    is_mem_o = (field_i == AOD_FIELD_MEM);
  end

endmodule
`default_nettype wire

/* core/aod_cycle_pick.sv */
// Chooses between the short and long cycle count of a flag-dependent instruction.
// Assumes the flag is already sampled in the processor clock domain.
`timescale 1ns/1ps
`default_nettype none
module aod_cycle_pick
  import aod_pkg::*;
(
  input wire logic dual_i,
  input wire logic cond_met_i,
  input wire logic [4:0] short_i,
  input wire logic [4:0] long_i,
  output logic [4:0] cycles_o
);

  always_comb begin
    cycles_o = (dual_i && cond_met_i) ? long_i : short_i;
  end

endmodule
`default_nettype wire

/* dv/aod_fetch_model.sv */
// Behavioural fetch path: hands the decoder opcode and operand bytes from a small memory.
// Assumes the bench preloads mem and pulses start_i; same clock as the decoder.
`timescale 1ns/1ps
`default_nettype none
module aod_fetch_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [3:0] addr_i,
  input wire logic slow_i,
  input wire logic busy_i,
  output logic op_valid_o,
  output logic [7:0] opcode_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  logic [7:0] mem [0:15];
  logic [3:0] op_addr_r;
  logic [3:0] pc_r;
  logic [1:0] wait_r;
  // Released lines show the inverse of their last value, so a stale byte never matches.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_valid_o <= 1'b0;
      byte_valid_o <= 1'b0;
      opcode_o <= 8'h00;
      byte_o <= 8'h00;
      pc_r <= 4'h0;
      op_addr_r <= 4'h0;
      wait_r <= 2'h0;
    end else begin
      if (op_valid_o && !busy_i) begin
        op_valid_o <= 1'b0;
        opcode_o <= ~opcode_o;
        pc_r <= op_addr_r + 4'h1;
      end
      if (byte_valid_o && busy_i) begin
        byte_valid_o <= 1'b0;
        byte_o <= ~byte_o;
        pc_r <= pc_r + 4'h1;
      end else if (busy_i && !byte_valid_o) begin
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end else begin
          byte_valid_o <= 1'b1;
          byte_o <= mem[pc_r];
        end
      end
      if (start_i) begin
        op_valid_o <= 1'b1;
        opcode_o <= mem[addr_i];
        op_addr_r <= addr_i;
        wait_r <= slow_i ? 2'h3 : 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/test_alu_opcode_decoder.sv */
// Self-checking bench for the opcode decoder, fed by the fetch model.
// Assumes one 200 MHz clock shared by decoder and model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module test_alu_opcode_decoder
  import aod_pkg::*;
;
  logic ref_clk, rst_b, start, slow, cond_met, op_valid, byte_valid;
  logic dec_valid, operand_valid, legal, busy;
  logic [3:0] addr;
  logic [7:0] opcode, byte_d, operand;
  logic [4:0] cycles;
  logic [1:0] pair, extra;
  aod_op_t op;
  aod_src_t src;
  aod_reg_t src_reg, dest_reg;
  int err_count, comparisons;

  aod_decoder uut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .op_valid_i(op_valid),
    .opcode_i(opcode), .cond_met_i(cond_met), .byte_valid_i(byte_valid), .byte_i(byte_d),
    .op_o(op), .src_o(src), .src_reg_o(src_reg), .dest_reg_o(dest_reg), .pair_o(pair),
    .cycles_o(cycles), .extra_bytes_o(extra), .legal_o(legal), .dec_valid_o(dec_valid),
    .operand_valid_o(operand_valid), .operand_o(operand), .busy_o(busy));
  aod_fetch_model fm (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .start_i(start), .addr_i(addr),
    .slow_i(slow), .busy_i(busy), .op_valid_o(op_valid), .opcode_o(opcode),
    .byte_valid_o(byte_valid), .byte_o(byte_d));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic end_sim();
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic issue(input logic [3:0] a, input logic s);
    @(posedge ref_clk);
    #1;
    start = 1'b1;
    addr = a;
    slow = s;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
  endtask

  // Waits for the decode pulse (sel 0) or the operand pulse (sel 1).
  task automatic wait_pulse(input logic sel);
    for (int n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      #2;
      if ((sel ? operand_valid : dec_valid) === 1'b1) return;
    end
    err_count++;
    $display("Error t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  endtask

  function automatic void ref_dec(input logic [7:0] o, output aod_op_t k,
                                  output logic [4:0] c, output logic [1:0] x);
    k = AOD_OP_ILLEGAL;
    c = 5'h04;
    x = 2'h0;
    if (o[7:6] == 2'h2) begin
      k = aod_op_t'(o[5:3] + 6'h1);
      c = (o[2:0] == 3'h6) ? 5'h07 : 5'h04;
    end else if (o[7:6] == 2'h3 && o[2:0] == 3'h6) begin
      k = aod_op_t'(o[5:3] + 6'h1);
      c = 5'h07;
      x = 2'h1;
    end else if (o[7:5] == 3'h0 && o[2:0] == 3'h7) begin
      k = aod_op_t'(o[4:3] + 6'h9);
    end else if (o[7:6] == 2'h0 && o[5:4] != 2'h3 && o[3:0] == 4'h9) begin
      k = AOD_OP_PAIR_SUM;
      c = 5'h0a;
    end else if (o[7:6] == 2'h0 && o[5:4] != 2'h3 && o[2:0] == 3'h3) begin
      k = o[3] ? AOD_OP_PAIR_DEC : AOD_OP_PAIR_INC;
      c = 5'h05;
    end else begin
      case (o)
        8'h2f: k = AOD_OP_INV_ACC;
        8'h37: k = AOD_OP_CARRY_SET;
        8'h3f: k = AOD_OP_CARRY_INV;
        8'h27: k = AOD_OP_DEC_ADJ;
        8'hfb: k = AOD_OP_INT_EN;
        8'hf3: k = AOD_OP_INT_MASK;
        8'h00: k = AOD_OP_IDLE;
        8'h76: begin
          k = AOD_OP_STOP;
          c = 5'h07;
        end
        8'hdb, 8'hd3: begin
          k = o[3] ? AOD_OP_PORT_IN : AOD_OP_PORT_OUT;
          c = 5'h0a;
          x = 2'h1;
        end
        default: ;
      endcase
    end
  endfunction

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic sweep_all();
    aod_op_t k;
    logic [4:0] c;
    logic [1:0] x;
    logic [7:0] o;
    for (int i = 0; i < 256; i++) begin
      o = i[7:0];
      ref_dec(o, k, c, x);
      fm.mem[0] = o;
      fm.mem[1] = o ^ 8'h5a;
      cond_met = o[0];
      issue(4'h0, 1'b0);
      wait_pulse(1'b0);
      if (o[7:6] == 2'h2) begin
        `CHK(op, k)
        `CHK(src, (o[2:0] == 3'h6) ? AOD_SRC_MEM : AOD_SRC_REG)
        `CHK(src_reg, aod_reg_t'(o[2:0]))
      end else if (o[7:6] == 2'h3 && o[2:0] == 3'h6) begin
        `CHK(op, k)
        `CHK(src, AOD_SRC_IMM)
      end else begin
        `CHK(op, k)
        `CHK(src, AOD_SRC_NONE)
      end
      `CHK(cycles, c)
      `CHK(extra, x)
      `CHK(legal, (k != AOD_OP_ILLEGAL))
      `CHK(dest_reg, aod_reg_t'(o[5:3]))
      if (k == AOD_OP_PAIR_SUM || k == AOD_OP_PAIR_INC || k == AOD_OP_PAIR_DEC) begin
        `CHK(pair, o[5:4])
      end
      if (x == 2'h1) begin
        wait_pulse(1'b1);
        `CHK(operand, o ^ 8'h5a)
      end
      `CHK(busy, 1'b0)
    end
  endtask

  // Slow operand, with a second opcode offered while the first still waits.
  task automatic stall_refuse();
    int early;
    early = 0;
    fm.mem[2] = 8'hfe;
    fm.mem[3] = 8'h3c;
    fm.mem[4] = 8'h80;
    issue(4'h2, 1'b1);
    wait_pulse(1'b0);
    `CHK(op, AOD_OP_COMPARE)
    `CHK(src, AOD_SRC_IMM)
    `CHK(busy, 1'b1)
    issue(4'h4, 1'b1);
    for (int n = 0; n < 20 && operand_valid !== 1'b1; n++) begin
      @(posedge ref_clk);
      #2;
      if (dec_valid === 1'b1) early++;
    end
    `CHK(operand_valid, 1'b1)
    if (operand_valid !== 1'b1) end_sim();
    `CHK(early, 0)
    `CHK(operand, 8'h3c)
    wait_pulse(1'b0);
    `CHK(op, AOD_OP_ADD)
    `CHK(src_reg, AOD_REG_B)
  endtask

  // Reset while an immediate opcode still waits for its operand byte.
  task automatic reset_mid();
    issue(4'h2, 1'b1);
    wait_pulse(1'b0);
    `CHK(busy, 1'b1)
    rst_b = 1'b0;
    #1;
    `CHK(busy, 1'b0)
    `CHK(op, AOD_OP_ILLEGAL)
    `CHK(cycles, AOD_CYC_RST)
    @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
  endtask

  task automatic back_to_back();
    fm.mem[5] = 8'h07;
    fm.mem[6] = 8'h1f;
    @(posedge ref_clk);
    #1;
    start = 1'b1;
    addr = 4'h5;
    @(posedge ref_clk);
    #1;
    addr = 4'h6;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    #1;
    `CHK(dec_valid, 1'b1)
    `CHK(op, AOD_OP_ROT_LEFT_CIRC)
    @(posedge ref_clk);
    #2;
    `CHK(dec_valid, 1'b1)
    `CHK(op, AOD_OP_ROT_RIGHT_CARRY)
  endtask

  initial begin
    start = 1'b0;
    slow = 1'b0;
    cond_met = 1'b0;
    addr = 4'h0;
    err_count = 0;
    comparisons = 0;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    `CHK(op, AOD_OP_ILLEGAL)
    `CHK(busy, 1'b0)
    sweep_all();
    stall_refuse();
    reset_mid();
    back_to_back();
    end_sim();
  end
endmodule
`default_nettype wire
